// file: timer16_consts.svh
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH
// Counter limits
`define T16_BOTTOM 16'h0000
`define T16_MAX 16'hffff
`define T16_TOP_8BIT 16'h00ff
`define T16_TOP_9BIT 16'h01ff
`define T16_TOP_10BIT 16'h03ff
// Clock select value that stops the counter
`define T16_CS_STOP 3'h0
// Noise filter sample count
`define T16_FILT_LEN 4
// Byte locations on the CPU port
`define T16_LOC_CNT_L 3'h0
`define T16_LOC_CNT_H 3'h1
`define T16_LOC_CAP_L 3'h2
`define T16_LOC_CAP_H 3'h3
`define T16_LOC_CMPA_L 3'h4
`define T16_LOC_CMPA_H 3'h5
`define T16_LOC_CMPB_L 3'h6
`define T16_LOC_CMPB_H 3'h7
`endif

// file: timer16_pkg.sv
`default_nettype none
package timer16_pkg;
  // Byte access request from the CPU
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] loc;
    logic [7:0] wdata;
  } cpu_req_t;
  // Counting sequence derived from the mode field
  typedef enum logic [1:0] {
    seq_up,
    seq_up_clear,
    seq_updown
  } seq_kind_t;
  // Source that defines the top of the sequence
  typedef enum logic [2:0] {
    top_max,
    top_8bit,
    top_9bit,
    top_10bit,
    top_cmpa,
    top_cap
  } top_src_t;
  typedef struct packed {
    seq_kind_t kind;
    top_src_t top;
    logic ovf_at_bottom;
  } mode_dec_t;
endpackage : timer16_pkg
`default_nettype wire

// file: timer16_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two flip-flop synchroniser for one asynchronous level
module timer16_sync (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q; // First stage, read only by second stage
  logic sync_q; // Second stage
  // Register both stages
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule : timer16_sync
`default_nettype wire

// file: timer16_filter.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer16_consts.svh"
// Noise filter: output follows input after LEN equal samples
module timer16_filter #(
  parameter int LEN = `T16_FILT_LEN
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_in,
  output logic o_out
);
  logic [LEN-2:0] hist_q; // Previous samples
  logic [LEN-2:0] hist_d;
  logic [LEN-1:0] win; // Previous samples with the current one
  logic out_q; // Filtered level
  logic out_d;
  // Judge the current sample with the stored ones, so the delay is LEN
  always_comb begin
    win = {hist_q, i_in};
    hist_d = win[LEN-2:0];
    out_d = out_q;
    if (&win) begin
      out_d = 1'b1;
    end else if (~|win) begin
      out_d = 1'b0;
    end
  end
  // Register filter state
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hist_q <= '0;
      out_q <= 1'b0;
    end else begin
      hist_q <= hist_d;
      out_q <= out_d;
    end
  end
  assign o_out = out_q;
endmodule : timer16_filter
`default_nettype wire

// file: timer16_counter_input_capture.sv
// Summary of operation
// - Clock select zero stops the counter
// - Timer tick counts up, down or clears
// - Clear zeroes counter; flag bottom and top
// - High-byte write reaches only shared latch
// - Counter or capture low read fills latch; low write commits
// - Counter accessible whether ticking or not
// - CPU write beats clear or count
// - Four-bit mode field picks the sequence
// - Overflow flag set per mode, interrupts
// - Selected edge copies counter to capture
// - Capture flag set with copy; interrupt
// - Flag clears on service or written one
// - Capture read low first, high via latch
// - Capture writable only in capture-top modes
// - Select bit switches trigger to comparator
// - Filter output changes after four agreements
// - Filter enable adds four system cycles
// - Captures suppressed when capture sets top
// - New capture overwrites unread value
// - Pin level captured even when self-driven
// - One latch shared by all wide registers
// - Compare reads bypass the shared latch
`timescale 1ns/100ps
`default_nettype none
`include "timer16_consts.svh"
module timer16_counter_input_capture #(
  parameter int WIDTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire timer16_pkg::cpu_req_t i_cpu, // Byte access
  input wire logic [2:0] i_clock_select_field,
  input wire logic [3:0] i_wave_mode_field, // Bits 1:0 in A, 3:2 in B
  input wire logic i_timer_tick, // Prescaled tick, same clock
  input wire logic i_noise_filter_enable,
  input wire logic i_capture_edge_rising,
  input wire logic i_comparator_capture_select,
  input wire logic i_capture_irq_enable,
  input wire logic i_overflow_irq_enable,
  input wire logic i_capture_irq_ack, // Capture vector serviced
  input wire logic i_overflow_irq_ack, // Overflow vector serviced
  input wire logic i_capture_flag_w1c,
  input wire logic i_overflow_flag_w1c,
  input wire logic i_capture_pin,
  input wire logic i_comparator_output,
  output logic [7:0] o_rdata,
  output logic [WIDTH-1:0] o_count_value,
  output logic o_bottom,
  output logic o_top,
  output logic o_capture_flag,
  output logic o_overflow_flag,
  output logic o_capture_irq,
  output logic o_overflow_irq
);
  // Decode the counting sequence from the mode field
  function automatic timer16_pkg::mode_dec_t dec_mode(
    input logic [3:0] m
  );
    timer16_pkg::mode_dec_t r;
    r.kind = timer16_pkg::seq_up;
    r.top = timer16_pkg::top_max;
    r.ovf_at_bottom = 1'b0;
    unique case (m)
      4'h0: r.top = timer16_pkg::top_max;
      4'h1: begin
        r.kind = timer16_pkg::seq_updown;
        r.top = timer16_pkg::top_8bit;
      end
      4'h2: begin
        r.kind = timer16_pkg::seq_updown;
        r.top = timer16_pkg::top_9bit;
      end
      4'h3: begin
        r.kind = timer16_pkg::seq_updown;
        r.top = timer16_pkg::top_10bit;
      end
      4'h4: begin
        r.kind = timer16_pkg::seq_up_clear;
        r.top = timer16_pkg::top_cmpa;
      end
      4'h5: r.top = timer16_pkg::top_8bit;
      4'h6: r.top = timer16_pkg::top_9bit;
      4'h7: r.top = timer16_pkg::top_10bit;
      4'h8: begin
        r.kind = timer16_pkg::seq_updown;
        r.top = timer16_pkg::top_cap;
        r.ovf_at_bottom = 1'b1;
      end
      4'h9: begin
        r.kind = timer16_pkg::seq_updown;
        r.top = timer16_pkg::top_cmpa;
        r.ovf_at_bottom = 1'b1;
      end
      4'ha: begin
        r.kind = timer16_pkg::seq_updown;
        r.top = timer16_pkg::top_cap;
      end
      4'hb: begin
        r.kind = timer16_pkg::seq_updown;
        r.top = timer16_pkg::top_cmpa;
      end
      4'hc: begin
        r.kind = timer16_pkg::seq_up_clear;
        r.top = timer16_pkg::top_cap;
      end
      4'hd: r.top = timer16_pkg::top_max; // Reserved, runs as normal
      4'he: r.top = timer16_pkg::top_cap;
      4'hf: r.top = timer16_pkg::top_cmpa;
    endcase
    return r;
  endfunction : dec_mode

  timer16_pkg::mode_dec_t md;
  logic [WIDTH-1:0] top_val; // Current top of sequence
  logic cap_is_top; // Capture register defines top
  logic trig_raw; // Synchronised selected trigger
  logic trig_filt; // Filtered trigger
  logic trig_sel; // Level into edge detector
  logic pin_sync;
  logic cmp_sync;
  logic trig_prev_q; // Edge detector history
  logic trig_prev_d;
  logic capture; // Capture event this cycle
  logic tick; // Active timer tick
  logic wr_cnt_lo; // CPU commit of counter
  logic wr_cap_lo; // CPU commit of capture register
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic [WIDTH-1:0] cap_q;
  logic [WIDTH-1:0] cap_d;
  logic [WIDTH-1:0] cmpa_q;
  logic [WIDTH-1:0] cmpa_d;
  logic [WIDTH-1:0] cmpb_q;
  logic [WIDTH-1:0] cmpb_d;
  logic [7:0] latch_q; // Shared high-byte latch
  logic [7:0] latch_d;
  logic down_q; // Direction, one counts down
  logic down_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic capf_q;
  logic capf_d;
  logic ovf_q;
  logic ovf_d;
  logic bot_q;
  logic bot_d;
  logic topf_q;
  logic topf_d;

  // Synchronise both trigger sources
  timer16_sync u_sync_pin (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_capture_pin),
    .o_sync(pin_sync)
  );
  timer16_sync u_sync_cmp (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_comparator_output),
    .o_sync(cmp_sync)
  );
  // Source selection
  assign trig_raw = i_comparator_capture_select ? cmp_sync : pin_sync;
  timer16_filter #(.LEN(`T16_FILT_LEN)) u_filter (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_in(trig_raw),
    .o_out(trig_filt)
  );

  // Mode decode, top value, tick gating and capture detection
  always_comb begin
    md = dec_mode(i_wave_mode_field);
    cap_is_top = (md.top == timer16_pkg::top_cap);
    unique case (md.top)
      timer16_pkg::top_8bit: top_val = `T16_TOP_8BIT;
      timer16_pkg::top_9bit: top_val = `T16_TOP_9BIT;
      timer16_pkg::top_10bit: top_val = `T16_TOP_10BIT;
      timer16_pkg::top_cmpa: top_val = cmpa_q;
      timer16_pkg::top_cap: top_val = cap_q;
      default: top_val = `T16_MAX;
    endcase
    tick = i_timer_tick && (i_clock_select_field != `T16_CS_STOP);
    trig_sel = i_noise_filter_enable ? trig_filt : trig_raw;
    trig_prev_d = trig_sel;
    capture = !cap_is_top &&
      (i_capture_edge_rising ? (trig_sel && !trig_prev_q)
                             : (!trig_sel && trig_prev_q));
    wr_cnt_lo = i_cpu.wr && !i_cpu.rd && (i_cpu.loc == `T16_LOC_CNT_L);
    wr_cap_lo = i_cpu.wr && (i_cpu.loc == `T16_LOC_CAP_L) && cap_is_top;
  end

  // Counter, direction and overflow sequencing
  always_comb begin
    cnt_d = cnt_q;
    down_d = down_q;
    // Clear first, so that a set further down in this process wins
    ovf_d = ovf_q && !(i_overflow_irq_ack || i_overflow_flag_w1c);
    if (tick) begin
      unique case (md.kind)
        timer16_pkg::seq_updown: begin
          if (!down_q && cnt_q >= top_val) begin
            down_d = 1'b1;
            cnt_d = cnt_q - 1'b1;
            if (!md.ovf_at_bottom) ovf_d = 1'b1;
          end else if (down_q && cnt_q == `T16_BOTTOM) begin
            down_d = 1'b0;
            cnt_d = cnt_q + 1'b1;
            if (md.ovf_at_bottom) ovf_d = 1'b1;
          end else begin
            cnt_d = down_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
          end
        end
        timer16_pkg::seq_up_clear: begin
          down_d = 1'b0;
          if (cnt_q == top_val) cnt_d = `T16_BOTTOM;
          else cnt_d = cnt_q + 1'b1;
          if (cnt_q == `T16_MAX) ovf_d = 1'b1;
        end
        default: begin
          down_d = 1'b0;
          if (cnt_q >= top_val) begin
            cnt_d = `T16_BOTTOM;
            ovf_d = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      endcase
    end
    if (wr_cnt_lo) cnt_d = {latch_q, i_cpu.wdata};
    bot_d = (cnt_d == `T16_BOTTOM);
    topf_d = (cnt_d == top_val);
  end

  // CPU byte access, shared latch, capture and compare registers
  always_comb begin
    latch_d = latch_q;
    rdata_d = rdata_q;
    cap_d = cap_q;
    cmpa_d = cmpa_q;
    cmpb_d = cmpb_q;
    capf_d = capf_q;
    if (i_capture_irq_ack || i_capture_flag_w1c) capf_d = 1'b0;
    if (capture) begin
      cap_d = cnt_q;
      capf_d = 1'b1;
    end
    if (i_cpu.rd) begin
      unique case (i_cpu.loc)
        `T16_LOC_CNT_L: begin
          rdata_d = cnt_q[7:0];
          latch_d = cnt_q[15:8];
        end
        `T16_LOC_CAP_L: begin
          rdata_d = cap_q[7:0];
          latch_d = cap_q[15:8];
        end
        `T16_LOC_CMPA_L: rdata_d = cmpa_q[7:0];
        `T16_LOC_CMPA_H: rdata_d = cmpa_q[15:8];
        `T16_LOC_CMPB_L: rdata_d = cmpb_q[7:0];
        `T16_LOC_CMPB_H: rdata_d = cmpb_q[15:8];
        default: rdata_d = latch_q;
      endcase
    end else if (i_cpu.wr) begin
      unique case (i_cpu.loc)
        `T16_LOC_CNT_H,
        `T16_LOC_CAP_H,
        `T16_LOC_CMPA_H,
        `T16_LOC_CMPB_H: latch_d = i_cpu.wdata;
        `T16_LOC_CMPA_L: cmpa_d = {latch_q, i_cpu.wdata};
        `T16_LOC_CMPB_L: cmpb_d = {latch_q, i_cpu.wdata};
        `T16_LOC_CAP_L: if (wr_cap_lo) cap_d = {latch_q, i_cpu.wdata};
        default: ;
      endcase
    end
  end

  // Register all state except the interrupt requests
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
      cap_q <= '0;
      cmpa_q <= '0;
      cmpb_q <= '0;
      latch_q <= 8'h00;
      down_q <= 1'b0;
      rdata_q <= 8'h00;
      capf_q <= 1'b0;
      ovf_q <= 1'b0;
      bot_q <= 1'b1;
      topf_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      cap_q <= cap_d;
      cmpa_q <= cmpa_d;
      cmpb_q <= cmpb_d;
      latch_q <= latch_d;
      down_q <= down_d;
      rdata_q <= rdata_d;
      capf_q <= capf_d;
      ovf_q <= ovf_d;
      bot_q <= bot_d;
      topf_q <= topf_d;
      trig_prev_q <= trig_prev_d;
    end
  end

  // Interrupt requests registered so outputs come from flip-flops
  logic capirq_q;
  logic ovfirq_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      capirq_q <= 1'b0;
      ovfirq_q <= 1'b0;
    end else begin
      capirq_q <= capf_d && i_capture_irq_enable;
      ovfirq_q <= ovf_d && i_overflow_irq_enable;
    end
  end

  assign o_rdata = rdata_q;
  assign o_count_value = cnt_q;
  assign o_bottom = bot_q;
  assign o_top = topf_q;
  assign o_capture_flag = capf_q;
  assign o_overflow_flag = ovf_q;
  assign o_capture_irq = capirq_q;
  assign o_overflow_irq = ovfirq_q;
endmodule : timer16_counter_input_capture
`default_nettype wire

// file: timer16_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer16_consts.svh"
// Port checker for the timer
module timer16_monitor #(
  parameter int WIDTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire timer16_pkg::cpu_req_t i_cpu,
  input wire logic [2:0] i_clock_select_field,
  input wire logic [3:0] i_wave_mode_field,
  input wire logic i_timer_tick,
  input wire logic i_noise_filter_enable,
  input wire logic i_capture_edge_rising,
  input wire logic i_comparator_capture_select,
  input wire logic i_capture_irq_enable,
  input wire logic i_capture_irq_ack,
  input wire logic i_capture_flag_w1c,
  input wire logic i_capture_pin,
  input wire logic [7:0] o_rdata,
  input wire logic [WIDTH-1:0] o_count_value,
  input wire logic o_bottom,
  input wire logic o_capture_flag,
  input wire logic o_capture_irq
);
  default clocking dcb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic cnt_wr; // CPU low write to the counter
  logic flag_clr; // Flag serviced or written one
  assign cnt_wr = i_cpu.wr && !i_cpu.rd && i_cpu.loc == `T16_LOC_CNT_L;
  assign flag_clr = i_capture_irq_ack || i_capture_flag_w1c;
  // Unfiltered pin rise that should capture
  sequence s_rise;
    $rose(i_capture_pin) && i_capture_edge_rising && !i_noise_filter_enable
      && !i_comparator_capture_select && i_wave_mode_field != 4'hc
      && i_wave_mode_field != 4'he && i_wave_mode_field != 4'h8
      && i_wave_mode_field != 4'ha;
  endsequence
  property p_stop;
    i_clock_select_field == `T16_CS_STOP && !i_cpu.wr
      |=> $stable(o_count_value);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");
  property p_step;
    i_timer_tick && i_clock_select_field != 3'h0 && !i_cpu.wr
      && i_wave_mode_field == 4'h0
      |=> o_count_value == WIDTH'($past(o_count_value) + 1);
  endproperty
  a_step: assert property (p_step) else $error("bad count step");
  property p_cpu_win;
    cnt_wr |=> o_count_value[7:0] == $past(i_cpu.wdata);
  endproperty
  a_cpu_win: assert property (p_cpu_win) else $error("write lost");
  property p_bottom;
    o_bottom == (o_count_value == '0);
  endproperty
  a_bottom: assert property (p_bottom) else $error("bottom wrong");
  property p_rd_low;
    i_cpu.rd && i_cpu.loc == `T16_LOC_CNT_L
      |=> o_rdata == $past(o_count_value[7:0]);
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("low read wrong");
  property p_cap_irq;
    o_capture_irq == (o_capture_flag && $past(i_capture_irq_enable));
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("irq wrong");
  property p_flag_hold;
    o_capture_flag && !flag_clr |=> o_capture_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_capture;
    s_rise ##1 (i_capture_pin && !flag_clr) [*3] |-> o_capture_flag;
  endproperty
  a_capture: assert property (p_capture) else $error("no capture");
  c_capture: cover property ($rose(o_capture_flag));
  c_bottom: cover property ($rose(o_bottom));
  c_cnt_wr: cover property (cnt_wr);
endmodule : timer16_monitor
bind timer16_counter_input_capture timer16_monitor #(.WIDTH(WIDTH)) mon_u (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cpu(i_cpu),
  .i_clock_select_field(i_clock_select_field),
  .i_wave_mode_field(i_wave_mode_field), .i_timer_tick(i_timer_tick),
  .i_noise_filter_enable(i_noise_filter_enable),
  .i_capture_edge_rising(i_capture_edge_rising),
  .i_comparator_capture_select(i_comparator_capture_select),
  .i_capture_irq_enable(i_capture_irq_enable),
  .i_capture_irq_ack(i_capture_irq_ack),
  .i_capture_flag_w1c(i_capture_flag_w1c), .i_capture_pin(i_capture_pin),
  .o_rdata(o_rdata), .o_count_value(o_count_value), .o_bottom(o_bottom),
  .o_capture_flag(o_capture_flag), .o_capture_irq(o_capture_irq)
);
`default_nettype wire

// file: timer16_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// CPU side of the byte port
module timer16_cpu_model (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  output var timer16_pkg::cpu_req_t o_req
);
  initial o_req = '0;
  // One byte access, held for one taking edge
  task automatic acc(input logic r, input logic [2:0] loc,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge i_ref_clk);
    o_req <= '{rd: r, wr: !r, loc: loc, wdata: d};
    @(posedge i_ref_clk);
    o_req <= '0;
    #1 q = i_rdata;
  endtask : acc
  // Wide write: high byte to the latch, low byte commits
  task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b0, lo + 3'h1, v[15:8], q);
    acc(1'b0, lo, v[7:0], q);
  endtask : wr16
  // Wide read: low byte first, high from the latch
  task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
    acc(1'b1, lo, 8'h00, v[7:0]);
    acc(1'b1, lo + 3'h1, 8'h00, v[15:8]);
  endtask : rd16
endmodule : timer16_cpu_model
`default_nettype wire

// file: test_timer16_counter_input_capture.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer16_consts.svh"
// Bench for the timer with input capture
module test_timer16_counter_input_capture;
  // Row: counter value written, bottom and top levels expected
  typedef struct packed {
    logic [15:0] val;
    logic bot;
    logic top;
  } row_t;
  row_t rows [4] = '{'{16'h0000, 1'b1, 1'b0}, '{16'h1234, 1'b0, 1'b0},
    '{16'hffff, 1'b0, 1'b1}, '{16'h80ff, 1'b0, 1'b0}};
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  timer16_pkg::cpu_req_t req; // From the CPU model
  logic [2:0] sel = 3'h0; // Clock select
  logic [3:0] mode = 4'h0; // Wave mode
  logic tick = 1'b0, filt = 1'b0, rise = 1'b1, cmp_sel = 1'b0;
  logic cap_en = 1'b0, ovf_en = 1'b0, cap_ack = 1'b0, ovf_ack = 1'b0;
  logic cap_w1c = 1'b0, ovf_w1c = 1'b0, pin = 1'b0, cmp_out = 1'b0;
  logic [7:0] rdata, b;
  logic [15:0] count, got;
  logic bottom, top, cap_flag, ovf_flag, cap_irq, ovf_irq;
  int compares = 0, miscompares = 0, cycles = 0;
  initial forever #20 ref_clk = ~ref_clk;
  timer16_counter_input_capture dut_u (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_cpu(req),
    .i_clock_select_field(sel), .i_wave_mode_field(mode),
    .i_timer_tick(tick), .i_noise_filter_enable(filt),
    .i_capture_edge_rising(rise), .i_comparator_capture_select(cmp_sel),
    .i_capture_irq_enable(cap_en), .i_overflow_irq_enable(ovf_en),
    .i_capture_irq_ack(cap_ack), .i_overflow_irq_ack(ovf_ack),
    .i_capture_flag_w1c(cap_w1c), .i_overflow_flag_w1c(ovf_w1c),
    .i_capture_pin(pin), .i_comparator_output(cmp_out), .o_rdata(rdata),
    .o_count_value(count), .o_bottom(bottom), .o_top(top),
    .o_capture_flag(cap_flag), .o_overflow_flag(ovf_flag),
    .o_capture_irq(cap_irq), .o_overflow_irq(ovf_irq)
  );
  timer16_cpu_model cpu_u (.i_ref_clk(ref_clk), .i_rdata(rdata), .o_req(req));
  // Compare and tally
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Wait a bounded time for the capture flag
  task automatic wait_flag(input int n);
    repeat (n) if (cap_flag !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
  endtask : wait_flag
  // Software writes one to the capture flag
  task automatic clear_flag;
    @(posedge ref_clk) cap_w1c <= 1'b1;
    @(posedge ref_clk) cap_w1c <= 1'b0;
    #1;
  endtask : clear_flag
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 2000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 chk({bottom, top, cap_flag, ovf_flag, cap_irq, ovf_irq}, 16'h0020);
    chk(count, 16'h0000);
    chk(rdata, 8'h00);
    @(posedge ref_clk) rst_b <= 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      cpu_u.wr16(`T16_LOC_CNT_L, rows[i].val);
      cpu_u.rd16(`T16_LOC_CNT_L, got);
      chk(got, rows[i].val);
      chk(bottom, rows[i].bot);
      chk(top, rows[i].top);
    end
    $display("table test done");
    cpu_u.acc(1'b0, `T16_LOC_CNT_H, 8'h55, b);
    chk(count, 16'h80ff);
    cpu_u.acc(1'b0, `T16_LOC_CMPA_L, 8'h66, b);
    cpu_u.acc(1'b0, `T16_LOC_CMPA_H, 8'h99, b);
    cpu_u.acc(1'b0, `T16_LOC_CNT_L, 8'h77, b);
    chk(count, 16'h9977);
    cpu_u.acc(1'b1, `T16_LOC_CNT_L, 8'h00, b);
    cpu_u.acc(1'b1, `T16_LOC_CMPA_L, 8'h00, b);
    chk(b, 8'h66);
    cpu_u.acc(1'b1, `T16_LOC_CMPA_H, 8'h00, b);
    chk(b, 8'h55);
    cpu_u.acc(1'b1, `T16_LOC_CNT_H, 8'h00, b);
    chk(b, 8'h99);
    $display("latch test done");
    cpu_u.wr16(`T16_LOC_CNT_L, 16'hfffe);
    @(posedge ref_clk) sel <= 3'h1;
    ovf_en <= 1'b1;
    tick <= 1'b1;
    repeat (2) @(posedge ref_clk);
    tick <= 1'b0;
    @(posedge ref_clk) #1 chk(count, 16'h0000);
    chk(bottom, 1'b1);
    chk({ovf_flag, ovf_irq}, 16'h0003);
    @(posedge ref_clk) ovf_w1c <= 1'b1;
    tick <= 1'b1;
    @(posedge ref_clk) ovf_w1c <= 1'b0;
    cpu_u.wr16(`T16_LOC_CNT_L, 16'h5a5a);
    chk(count, 16'h5a5a);
    chk(ovf_flag, 1'b0);
    @(posedge ref_clk) sel <= 3'h0;
    repeat (3) @(posedge ref_clk);
    tick <= 1'b0;
    #1 chk(count, 16'h5a5b);
    $display("count test done");
    cpu_u.wr16(`T16_LOC_CNT_L, 16'h4321);
    @(posedge ref_clk) pin <= 1'b1;
    cap_en <= 1'b1;
    wait_flag(8);
    chk({cap_flag, cap_irq}, 16'h0003);
    cpu_u.rd16(`T16_LOC_CAP_L, got);
    chk(got, 16'h4321);
    @(posedge ref_clk) rise <= 1'b0;
    clear_flag();
    chk(cap_flag, 1'b0);
    cpu_u.wr16(`T16_LOC_CNT_L, 16'h0777);
    @(posedge ref_clk) rise <= 1'b0;
    pin <= 1'b0;
    wait_flag(8);
    cpu_u.rd16(`T16_LOC_CAP_L, got);
    chk(got, 16'h0777);
    @(posedge ref_clk) cap_ack <= 1'b1;
    @(posedge ref_clk) cap_ack <= 1'b0;
    #1 chk(cap_flag, 1'b0);
    $display("capture test done");
    cpu_u.wr16(`T16_LOC_CNT_L, 16'h0abc);
    @(posedge ref_clk) cmp_sel <= 1'b1;
    rise <= 1'b1;
    repeat (6) @(posedge ref_clk);
    clear_flag();
    @(posedge ref_clk) cmp_out <= 1'b1;
    wait_flag(8);
    cpu_u.rd16(`T16_LOC_CAP_L, got);
    chk(got, 16'h0abc);
    @(posedge ref_clk) cmp_sel <= 1'b0;
    filt <= 1'b1;
    repeat (6) @(posedge ref_clk);
    clear_flag();
    @(posedge ref_clk) pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    pin <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 chk(cap_flag, 1'b0);
    @(posedge ref_clk) pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 chk(cap_flag, 1'b0);
    @(posedge ref_clk);
    #1 chk(cap_flag, 1'b1);
    $display("trigger test done");
    @(posedge ref_clk) mode <= 4'hc;
    filt <= 1'b0;
    pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    clear_flag();
    @(posedge ref_clk) pin <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 chk(cap_flag, 1'b0);
    cpu_u.wr16(`T16_LOC_CAP_L, 16'hbeef);
    cpu_u.rd16(`T16_LOC_CAP_L, got);
    chk(got, 16'hbeef);
    @(posedge ref_clk) pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    mode <= 4'h0;
    cpu_u.wr16(`T16_LOC_CAP_L, 16'h1111);
    cpu_u.rd16(`T16_LOC_CAP_L, got);
    chk(got, 16'hbeef);
    $display("top mode test done");
    finish_test();
  end
endmodule : test_timer16_counter_input_capture
`default_nettype wire
